// >>> core/mgmt_mailbox.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
// How it works
// - pointer register returns shared memory base when the processor is running.
// - each port has command, response and two pulse mailboxes.
// - command word holds code in bits 31:16, sequence in 15:0.
// - response word holds code in bits 31:16, sequence in 15:0.
// - host writes only command and pulse words; processor writes only response.
// - host increments sequence; response copies the command's sequence.
// - load request answered with common-init, port-init or function-init.
// - first load request always gets common-init.
// - later load requests get port-init on a port's first request once common-init has been answered, else function-init.
// - init-complete command is answered by init-complete response.
// - pulse words share the code and sequence layout.
// - missing heartbeat lets the processor take over the link.
// - always-alive flag disables the heartbeat check.
// - drain bit set stops transmit by clearing tx enable.
// - host writes drain through the register port; controller clears it on link-up while it owns a port's link.
// - microengine firmware reads back unchanged.
module mgmt_mailbox #(
  parameter int HB_TIMEOUT_CYC_P = mbx_pkg::HB_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     srst_i,
  // register port
  input  wire mbx_pkg::addr_t           addr_i,
  input  wire mbx_pkg::word_t           wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output mbx_pkg::word_t                rdata_o,
  // pins
  input  wire logic                     mgmt_run_i,
  input  wire logic                     link_up_i,
  // link and transmit control
  output logic                          drain_o,
  output logic                          tx_enable_o,
  output logic [mbx_pkg::NPORT-1:0]     link_owner_o
);
  import mbx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  port_mbox_if pif [NPORT] ();

  logic [1:0]        sy1_q, sy2_q;
  logic              lk_prev_q, lk_rise, run;
  logic              in_mbx, in_fw, port_sel;
  logic [1:0]        word_sel;
  logic [NPORT-1:0]  pend, lost;
  word_t             cmd_w [NPORT];
  word_t             rsp_v [NPORT];
  word_t             pin_v [NPORT];
  word_t             pout_v [NPORT];
  word_t             fw_rdata, rdata_d, rdata_q;
  resp_state_e       state_q;
  logic              svc_q, last_q;
  logic              common_q;
  logic [NPORT-1:0]  port_init_q;
  logic              rsp_we_q;
  word_t             rsp_word_q;
  code_t             rsp_code_d, svc_code;
  logic [15:0]       svc_seq;
  logic              alive_q, drain_q, drain_d, tx_en_q;
  logic              drain_wr;
  logic [NPORT-1:0]  own_q;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: bit 0 run, bit 1 link up
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sy1_q <= 2'h0;
      sy2_q <= 2'h0;
    end else begin
      sy1_q <= {link_up_i, mgmt_run_i};
      sy2_q <= sy1_q;
    end
  end
  assign run = sy2_q[0];

  // link-up edge from the second stage
  always_ff @(posedge clock_i) begin
    if (srst_i) lk_prev_q <= 1'b0;
    else lk_prev_q <= sy2_q[1];
  end
  assign lk_rise = sy2_q[1] && !lk_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  assign in_mbx   = (addr_i & MBX_MASK) == SHMEM_BASE;
  assign in_fw    = (addr_i & FW_MASK) == FW_BASE;
  assign port_sel = addr_i[MBX_PORT_BIT];
  assign word_sel = addr_i[WORD_SEL_MSB:WORD_SEL_LSB];
  assign drain_wr = wr_i && addr_i == DRAIN_ADDR;

  ////////////////////////////////////////////////////////////////////////////
  // per-port mailbox groups
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    // host writes reach only the command and host pulse words
    assign pif[p].wdata    = wdata_i;
    assign pif[p].cmd_we   = wr_i && in_mbx && port_sel == 1'(p) && word_sel == WORD_CMD;
    assign pif[p].pulse_we = wr_i && in_mbx && port_sel == 1'(p) && word_sel == WORD_PH2P;
    assign pif[p].alive    = alive_q;
    assign pif[p].rsp_we   = rsp_we_q && svc_q == 1'(p);
    assign pif[p].rsp_word = rsp_word_q;

    port_mailbox #(
      .HB_CYC (HB_TIMEOUT_CYC_P)
    ) u_port (
      .clock_i (clock_i),
      .srst_i  (srst_i),
      .mb      (pif[p].mbox)
    );

    // gather state for the responder and read mux
    assign pend[p]   = pif[p].pending;
    assign lost[p]   = pif[p].hb_lost;
    assign cmd_w[p]  = pif[p].cmd_word;
    assign rsp_v[p]  = pif[p].rsp_cur;
    assign pin_v[p]  = pif[p].pulse_in;
    assign pout_v[p] = pif[p].pulse_out;
  end

  ////////////////////////////////////////////////////////////////////////////
  // microengine image store
  fw_store u_fw (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .we_i    (wr_i && in_fw),
    .idx_i   (addr_i[FW_IDX_MSB:WORD_SEL_LSB]),
    .wdata_i (wdata_i),
    .rdata_o (fw_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // fields of the command under service
  assign svc_code = cmd_w[svc_q][CODE_MSB:CODE_LSB];
  assign svc_seq  = cmd_w[svc_q][SEQ_MSB:SEQ_LSB];

  // answer selection from the shared init state
  always_comb begin
    rsp_code_d = RSP_UNSUPPORTED;
    case (svc_code)
      CMD_LOAD_REQ: begin
        if (!common_q) rsp_code_d = RSP_LOAD_COMMON;
        else if (!port_init_q[svc_q]) rsp_code_d = RSP_LOAD_PORT;
        else rsp_code_d = RSP_LOAD_FUNC;
      end
      CMD_LOAD_DONE: rsp_code_d = RSP_LOAD_DONE;
      default: rsp_code_d = RSP_UNSUPPORTED;
    endcase
  end

  // responder sequence, alternating between ports
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_q <= ST_IDLE;
      svc_q   <= 1'b0;
      last_q  <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (run && |pend) begin
            svc_q   <= pend[~last_q] ? ~last_q : last_q;
            state_q <= ST_DECODE;
          end
        end
        ST_DECODE: state_q <= ST_POST;
        ST_POST: begin
          last_q  <= svc_q;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // response word with the command's sequence copied
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rsp_we_q   <= 1'b0;
      rsp_word_q <= WORD_RST;
    end else begin
      rsp_we_q <= state_q == ST_DECODE;
      if (state_q == ST_DECODE) rsp_word_q <= {rsp_code_d, svc_seq};
    end
  end

  // shared and per-port init tracking
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      common_q    <= 1'b0;
      port_init_q <= '0;
    end else if (state_q == ST_DECODE && svc_code == CMD_LOAD_REQ) begin
      common_q           <= 1'b1;
      port_init_q[svc_q] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // always-alive flag
  always_ff @(posedge clock_i) begin
    if (srst_i) alive_q <= ALIVE_RST;
    else if (wr_i && addr_i == MGMT_CTRL_ADDR) alive_q <= wdata_i[ALIVE_BIT];
  end

  // link ownership follows heartbeat loss
  always_ff @(posedge clock_i) begin
    if (srst_i) own_q <= '0;
    else own_q <= lost;
  end

  // drain: host write wins over the link-up clear
  always_comb begin
    drain_d = drain_q;
    if (drain_wr) drain_d = wdata_i[DRAIN_BIT];
    else if (lk_rise && |own_q) drain_d = 1'b0;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      drain_q <= DRAIN_RST;
      tx_en_q <= ~DRAIN_RST;
    end else begin
      drain_q <= drain_d;
      tx_en_q <= ~drain_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rdata_d = WORD_RST;
    if (in_mbx) begin
      case (word_sel)
        WORD_CMD:  rdata_d = cmd_w[port_sel];
        WORD_RSP:  rdata_d = rsp_v[port_sel];
        WORD_PH2P: rdata_d = pin_v[port_sel];
        default:   rdata_d = pout_v[port_sel];
      endcase
    end else if (in_fw) begin
      rdata_d = fw_rdata;
    end else begin
      case (addr_i)
        SHMEM_PTR_ADDR: rdata_d = run ? 32'(SHMEM_BASE) : PTR_DEAD;
        DRAIN_ADDR:     rdata_d = 32'(drain_q);
        MGMT_CTRL_ADDR: rdata_d = 32'(alive_q);
        MGMT_STAT_ADDR: rdata_d = 32'({run, own_q, common_q});
        default:        rdata_d = WORD_RST;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (srst_i) rdata_q <= WORD_RST;
    else rdata_q <= rd_i ? rdata_d : WORD_RST;
  end

  assign rdata_o      = rdata_q;
  assign drain_o      = drain_q;
  assign tx_enable_o  = tx_en_q;
  assign link_owner_o = own_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  // pointer register
  ptr_live_a: assert property (
    rd_i && addr_i == SHMEM_PTR_ADDR && run |=> rdata_o == 32'(SHMEM_BASE))
    else $error("pointer wrong while running");
  ptr_dead_a: assert property (
    rd_i && addr_i == SHMEM_PTR_ADDR && !run |=> rdata_o == PTR_DEAD)
    else $error("pointer nonzero while stopped");

  // load and done answers
  first_common_a: assert property (
    state_q == ST_DECODE && svc_code == CMD_LOAD_REQ && !common_q
    |=> rsp_we_q && rsp_word_q[CODE_MSB:CODE_LSB] == RSP_LOAD_COMMON)
    else $error("first load not common");
  later_port_a: assert property (
    state_q == ST_DECODE && svc_code == CMD_LOAD_REQ && common_q && !port_init_q[svc_q]
    |=> rsp_word_q[CODE_MSB:CODE_LSB] == RSP_LOAD_PORT)
    else $error("later load not port");
  func_repeat_a: assert property (
    state_q == ST_DECODE && svc_code == CMD_LOAD_REQ && common_q && port_init_q[svc_q]
    |=> rsp_word_q[CODE_MSB:CODE_LSB] == RSP_LOAD_FUNC)
    else $error("repeat load not function");
  done_answer_a: assert property (
    state_q == ST_DECODE && svc_code == CMD_LOAD_DONE
    |=> rsp_word_q[CODE_MSB:CODE_LSB] == RSP_LOAD_DONE)
    else $error("done not answered");
  seq_copy_a: assert property (
    state_q == ST_DECODE |=> rsp_we_q && rsp_word_q[SEQ_MSB:SEQ_LSB] == $past(svc_seq))
    else $error("sequence not copied");

  // mailbox words
  cmd_land_a: assert property (
    wr_i && in_mbx && !port_sel && word_sel == WORD_CMD |=> cmd_w[0] == $past(wdata_i))
    else $error("command word not written");
  pend_set_a: assert property (
    wr_i && in_mbx && !port_sel && word_sel == WORD_CMD |=> pend[0])
    else $error("command not pending");
  rsp_ro_a: assert property (
    !rsp_we_q |=> rsp_v[0] == $past(rsp_v[0]) && rsp_v[1] == $past(rsp_v[1]))
    else $error("response word changed without responder");
  pulse_echo_a: assert property (
    wr_i && in_mbx && !port_sel && word_sel == WORD_PH2P |=> pout_v[0] == $past(wdata_i))
    else $error("pulse word not echoed");

  // drain, heartbeat and link ownership
  drain_tx_a: assert property (drain_o |-> !tx_enable_o)
    else $error("transmit while draining");
  drain_write_a: assert property (
    drain_wr |=> drain_o == $past(wdata_i[DRAIN_BIT]))
    else $error("drain write lost");
  linkup_clr_a: assert property (
    lk_rise && |own_q && !drain_wr |=> !drain_o)
    else $error("drain kept on link-up");
  take_over_a: assert property (
    $rose(lost[0]) |=> link_owner_o[0] ##1 link_owner_o[0])
    else $error("no link take-over");
  owner_follow_a: assert property (
    1'b1 |=> link_owner_o == $past(lost))
    else $error("owner does not follow heartbeat loss");
  alive_write_a: assert property (
    wr_i && addr_i == MGMT_CTRL_ADDR |=> alive_q == $past(wdata_i[ALIVE_BIT]))
    else $error("always-alive flag not written");

  // main scenarios
  common_c: cover property (rsp_we_q && rsp_word_q[CODE_MSB:CODE_LSB] == RSP_LOAD_COMMON);
  port_c:   cover property (rsp_we_q && rsp_word_q[CODE_MSB:CODE_LSB] == RSP_LOAD_PORT);
  func_c:   cover property (rsp_we_q && rsp_word_q[CODE_MSB:CODE_LSB] == RSP_LOAD_FUNC);
  own_c:    cover property ($rose(link_owner_o[1]));
  drain_c:  cover property (drain_o ##1 !drain_o);

endmodule : mgmt_mailbox

// >>> core/mbx_pkg.sv
package mbx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_MHZ        = 10;
  localparam int HB_TIMEOUT_US  = 1000;
  localparam int HB_TIMEOUT_CYC = HB_TIMEOUT_US * CLK_MHZ;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int ADDR_W    = 20;
  localparam int NPORT     = 2;
  localparam int FW_DEPTH  = 16;
  localparam int FW_IDX_W  = 4;
  localparam int HB_CNT_W  = 16;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [31:0]       word_t;
  typedef logic [15:0]       code_t;

  ////////////////////////////////////////////////////////////////////////////
  // mailbox word layout: code high half, sequence low half
  localparam int CODE_MSB = 31;
  localparam int CODE_LSB = 16;
  localparam int SEQ_MSB  = 15;
  localparam int SEQ_LSB  = 0;

  ////////////////////////////////////////////////////////////////////////////
  // byte addresses
  localparam addr_t SHMEM_PTR_ADDR = 20'h0A2B4;
  localparam addr_t DRAIN_ADDR     = 20'h10060;
  localparam addr_t SHMEM_BASE     = 20'h20000;
  localparam addr_t MBX_MASK       = 20'hFFFE0;
  localparam addr_t MGMT_CTRL_ADDR = 20'h20040;
  localparam addr_t MGMT_STAT_ADDR = 20'h20044;
  localparam addr_t FW_BASE        = 20'h30000;
  localparam addr_t FW_MASK        = 20'hFFFC0;
  localparam int    MBX_PORT_BIT   = 4;
  localparam int    WORD_SEL_MSB   = 3;
  localparam int    WORD_SEL_LSB   = 2;
  localparam int    FW_IDX_MSB     = 5;

  // word select inside one port's mailbox group
  localparam logic [1:0] WORD_CMD   = 2'h0;
  localparam logic [1:0] WORD_RSP   = 2'h1;
  localparam logic [1:0] WORD_PH2P  = 2'h2;
  localparam logic [1:0] WORD_PP2H  = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // bit positions and reset values
  localparam int    DRAIN_BIT      = 0;
  localparam int    ALIVE_BIT      = 0;
  localparam int    STAT_COMMON    = 0;
  localparam int    STAT_OWN_LSB   = 1;
  localparam int    STAT_RUN       = 3;
  localparam logic  DRAIN_RST      = 1'b0;
  localparam logic  ALIVE_RST      = 1'b0;
  localparam word_t WORD_RST       = 32'h0000_0000;
  localparam word_t PTR_DEAD       = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // command and response codes (values arbitrary)
  localparam code_t CMD_LOAD_REQ    = 16'h1000;
  localparam code_t CMD_LOAD_DONE   = 16'h1100;
  localparam code_t RSP_LOAD_COMMON = 16'h1010;
  localparam code_t RSP_LOAD_PORT   = 16'h1011;
  localparam code_t RSP_LOAD_FUNC   = 16'h1012;
  localparam code_t RSP_LOAD_DONE   = 16'h1110;
  localparam code_t RSP_UNSUPPORTED = 16'hFFFF;

  // responder states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_DECODE = 3'b010,
    ST_POST   = 3'b100
  } resp_state_e;

endpackage : mbx_pkg

// >>> core/port_mbox_if.sv
`timescale 1ns/1ps
interface port_mbox_if;
  // bus side writes
  mbx_pkg::word_t wdata;
  logic           cmd_we;
  logic           pulse_we;
  logic           alive;
  // responder side writes
  logic           rsp_we;
  mbx_pkg::word_t rsp_word;
  // mailbox state
  mbx_pkg::word_t cmd_word;
  mbx_pkg::word_t rsp_cur;
  mbx_pkg::word_t pulse_in;
  mbx_pkg::word_t pulse_out;
  logic           pending;
  logic           hb_lost;

  modport mbox (
    input  wdata, cmd_we, pulse_we, alive, rsp_we, rsp_word,
    output cmd_word, rsp_cur, pulse_in, pulse_out, pending, hb_lost
  );
  modport ctrl (
    output wdata, cmd_we, pulse_we, alive, rsp_we, rsp_word,
    input  cmd_word, rsp_cur, pulse_in, pulse_out, pending, hb_lost
  );
endinterface : port_mbox_if

// >>> core/port_mailbox.sv
`timescale 1ns/1ps
module port_mailbox #(
  parameter int HB_CYC = mbx_pkg::HB_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic   clock_i,
  input wire logic   srst_i,
  // mailbox group
  port_mbox_if.mbox  mb
);
  import mbx_pkg::*;

  word_t               cmd_q, rsp_q, pin_q, pout_q;
  logic                pend_q, armed_q, lost_q;
  logic [HB_CNT_W-1:0] cnt_q;
  logic                expire;

  // command word, written by the host only
  always_ff @(posedge clock_i) begin
    if (srst_i) cmd_q <= WORD_RST;
    else if (mb.cmd_we) cmd_q <= mb.wdata;
  end

  // pending: new command sets, matching response clears
  always_ff @(posedge clock_i) begin
    if (srst_i) pend_q <= 1'b0;
    else if (mb.cmd_we) pend_q <= 1'b1;
    else if (mb.rsp_we && mb.rsp_word[SEQ_MSB:SEQ_LSB] == cmd_q[SEQ_MSB:SEQ_LSB]) begin
      pend_q <= 1'b0;
    end
  end

  // response word, written by the responder only
  always_ff @(posedge clock_i) begin
    if (srst_i) rsp_q <= WORD_RST;
    else if (mb.rsp_we) rsp_q <= mb.rsp_word;
  end

  // pulse words: echo with the same code and sequence layout
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pin_q  <= WORD_RST;
      pout_q <= WORD_RST;
    end else if (mb.pulse_we) begin
      pin_q  <= mb.wdata;
      pout_q <= mb.wdata;
    end
  end

  // heartbeat watchdog, off while the host claims always alive
  assign expire = armed_q && !lost_q && !mb.alive && (cnt_q == HB_CNT_W'(HB_CYC - 1));
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      armed_q <= 1'b0;
      cnt_q   <= '0;
      lost_q  <= 1'b0;
    end else begin
      if (mb.pulse_we) armed_q <= 1'b1;
      if (mb.pulse_we || mb.alive) cnt_q <= '0;
      else if (armed_q && !lost_q && !expire) cnt_q <= cnt_q + 1'b1;
      if (expire) lost_q <= 1'b1;
      else if (mb.pulse_we) lost_q <= 1'b0;
    end
  end

  assign mb.cmd_word  = cmd_q;
  assign mb.rsp_cur   = rsp_q;
  assign mb.pulse_in  = pin_q;
  assign mb.pulse_out = pout_q;
  assign mb.pending   = pend_q;
  assign mb.hb_lost   = lost_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  pend_hold_a: assert property (@(posedge clock_i) disable iff (srst_i)
    pend_q && !(mb.rsp_we && mb.rsp_word[SEQ_MSB:SEQ_LSB] == cmd_q[SEQ_MSB:SEQ_LSB])
    |=> pend_q) else $error("pending dropped without matching response");
  alive_mask_a: assert property (@(posedge clock_i) disable iff (srst_i)
    mb.alive && !lost_q |=> !lost_q) else $error("heartbeat lost while always alive");

endmodule : port_mailbox

// >>> core/fw_store.sv
`timescale 1ns/1ps
module fw_store (
  // clock and reset
  input  wire logic                    clock_i,
  input  wire logic                    srst_i,
  // access
  input  wire logic                    we_i,
  input  wire logic [mbx_pkg::FW_IDX_W-1:0] idx_i,
  input  wire mbx_pkg::word_t          wdata_i,
  output mbx_pkg::word_t               rdata_o
);
  import mbx_pkg::*;

  word_t mem_q [FW_DEPTH];

  // image words, read back unchanged
  always_ff @(posedge clock_i) begin
    if (we_i) mem_q[idx_i] <= wdata_i;
  end
  assign rdata_o = mem_q[idx_i];

  readback_a: assert property (@(posedge clock_i) disable iff (srst_i)
    we_i ##1 (idx_i == $past(idx_i)) |-> rdata_o == $past(wdata_i))
    else $error("image word not read back");

endmodule : fw_store

// >>> verif/host_driver_model.sv
`timescale 1ns/1ps
module host_driver_model (
  // clock
  input  wire logic            clock_i,
  // register port
  output mbx_pkg::addr_t       addr_o,
  output mbx_pkg::word_t       wdata_o,
  output logic                 wr_o,
  output logic                 rd_o,
  input  wire mbx_pkg::word_t  rdata_i
);
  import mbx_pkg::*;

  // idle bus at time zero
  initial begin
    addr_o  = '0;
    wdata_o = '0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle write; released lines show the inverse
  task automatic wr(input addr_t a, input word_t d);
    @(posedge clock_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clock_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask : wr

  // one-cycle read; data taken in the following cycle only
  task automatic rd(input addr_t a, output word_t d);
    @(posedge clock_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clock_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    @(negedge clock_i);
    d = rdata_i;
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  // post one command, poll response sequence with a bound
  task automatic cmd(input int p, input code_t c, input logic [15:0] s,
                     output word_t early, output word_t r);
    addr_t a;
    int    n;
    a = SHMEM_BASE + addr_t'(p * 16);
    wr(a, {c, s});
    rd(a + addr_t'(4), early);
    r = early;
    n = 0;
    while (r[SEQ_MSB:SEQ_LSB] !== s && n < 50) begin
      rd(a + addr_t'(4), r);
      n++;
    end
  endtask : cmd
endmodule : host_driver_model

// >>> verif/mgmt_mailbox_bench.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); \
    end \
  end

module mgmt_mailbox_bench;
  import mbx_pkg::*;

  localparam int HB = 20;

  logic             clock_i;
  logic             srst_i;
  addr_t            addr;
  word_t            wdata;
  logic             wr;
  logic             rd;
  word_t            rdata;
  logic             mgmt_run;
  logic             link_up;
  logic             drain;
  logic             tx_en;
  logic [NPORT-1:0] owner;
  int               mismatches = 0;
  int               checked    = 0;
  int               cyc        = 0;

  ////////////////////////////////////////////////////////////////////////////
  // instances
  mgmt_mailbox #(.HB_TIMEOUT_CYC_P(HB)) i_mgmt_mailbox (
    .clock_i(clock_i), .srst_i(srst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .mgmt_run_i(mgmt_run),
    .link_up_i(link_up), .drain_o(drain), .tx_enable_o(tx_en),
    .link_owner_o(owner)
  );

  host_driver_model i_host_driver_model (
    .clock_i(clock_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
    .rd_o(rd), .rdata_i(rdata)
  );

  // clock and hang guard
  initial clock_i = 1'b0;
  always #50 clock_i = ~clock_i;

  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic results;
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  task automatic rd_chk(input string nm, input addr_t a, input word_t exp);
    word_t got;
    i_host_driver_model.rd(a, got);
    `CHK(nm, exp, got)
  endtask : rd_chk

  task automatic do_cmd(input int p, input code_t c, input logic [15:0] s,
                        input word_t old, input word_t exp);
    word_t early;
    word_t got;
    i_host_driver_model.cmd(p, c, s, early, got);
    `CHK("early response", old, early)
    `CHK("response", exp, got)
  endtask : do_cmd

  task automatic settle(input int n);
    repeat (n) @(negedge clock_i);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    settle(1);
    `CHK("drain", 1'b0, drain)
    `CHK("tx enable", 1'b1, tx_en)
    `CHK("owner", 2'h0, owner)
    rd_chk("pointer stopped", SHMEM_PTR_ADDR, PTR_DEAD);
  endtask : t_reset

  task automatic t_pointer;
    @(posedge clock_i);
    mgmt_run <= 1'b1;
    settle(4);
    rd_chk("pointer", SHMEM_PTR_ADDR, word_t'(SHMEM_BASE));
    i_host_driver_model.wr(SHMEM_PTR_ADDR, 32'hFFFF_FFFF);
    rd_chk("pointer ro", SHMEM_PTR_ADDR, word_t'(SHMEM_BASE));
    rd_chk("unmapped", 20'h00100, 32'h0000_0000);
  endtask : t_pointer

  task automatic t_load;
    do_cmd(0, CMD_LOAD_REQ, 16'h0001, WORD_RST, {RSP_LOAD_COMMON, 16'h0001});
    rd_chk("command", SHMEM_BASE, {CMD_LOAD_REQ, 16'h0001});
    t_fw();
    do_cmd(1, CMD_LOAD_REQ, 16'h0001, WORD_RST, {RSP_LOAD_PORT, 16'h0001});
    do_cmd(0, CMD_LOAD_DONE, 16'h0002, {RSP_LOAD_COMMON, 16'h0001},
           {RSP_LOAD_DONE, 16'h0002});
    do_cmd(0, CMD_LOAD_REQ, 16'h0003, {RSP_LOAD_DONE, 16'h0002},
           {RSP_LOAD_FUNC, 16'h0003});
    do_cmd(1, 16'h0ABC, 16'h0002, {RSP_LOAD_PORT, 16'h0001},
           {RSP_UNSUPPORTED, 16'h0002});
    i_host_driver_model.wr(SHMEM_BASE + 20'h00014, 32'h1234_5678);
    rd_chk("response ro", SHMEM_BASE + 20'h00014, {RSP_UNSUPPORTED, 16'h0002});
    rd_chk("status", MGMT_STAT_ADDR, 32'h0000_0009);
  endtask : t_load

  task automatic t_heartbeat;
    i_host_driver_model.wr(SHMEM_BASE + 20'h00008, 32'h5A5A_0001);
    rd_chk("pulse echo", SHMEM_BASE + 20'h0000C, 32'h5A5A_0001);
    settle(10);
    `CHK("owner kept", 2'h0, owner)
    settle(HB + 10);
    `CHK("owner lost", 2'h1, owner)
    i_host_driver_model.wr(DRAIN_ADDR, 32'h0000_0001);
    settle(2);
    `CHK("drain on", 1'b1, drain)
    `CHK("tx off", 1'b0, tx_en)
    rd_chk("drain reg", DRAIN_ADDR, 32'h0000_0001);
    @(posedge clock_i);
    link_up <= 1'b1;
    settle(6);
    `CHK("drain cleared", 1'b0, drain)
    `CHK("tx back", 1'b1, tx_en)
    @(posedge clock_i);
    link_up <= 1'b0;
    i_host_driver_model.wr(SHMEM_BASE + 20'h00008, 32'h5A5A_0002);
    settle(3);
    `CHK("owner back", 2'h0, owner)
    i_host_driver_model.wr(MGMT_CTRL_ADDR, 32'h0000_0001);
    settle(HB + 20);
    `CHK("always alive", 2'h0, owner)
  endtask : t_heartbeat

  task automatic t_fw;
    for (int i = 0; i < FW_DEPTH; i++) begin
      i_host_driver_model.wr(FW_BASE + addr_t'(i * 4), {16'hC0DE, 16'(i)});
    end
    for (int i = 0; i < FW_DEPTH; i++) begin
      rd_chk("image", FW_BASE + addr_t'(i * 4), {16'hC0DE, 16'(i)});
    end
  endtask : t_fw

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    srst_i   = 1'b1;
    mgmt_run = 1'b0;
    link_up  = 1'b0;
    repeat (10) @(posedge clock_i);
    srst_i <= 1'b0;
    t_reset();
    t_pointer();
    t_load();
    t_heartbeat();
    results();
  end
endmodule : mgmt_mailbox_bench
